// ---- include/pcw_pkg.sv ----
// Purpose: Constants and types for the position control, watch and homing block
// Assumes: One 10 MHz control update clock; registers are 32-bit words
// Notes on behaviour
// - Output enable routes regulator to speed output
// - Integrator enable runs it; clear resets it
// - Hold bit freezes the integrator value
// - Polarity bit inverts position offset sign
// - Re-reference bit keeps actual through offset changes
// - Set-zero works only in absolute, not running
// - Re-reference bit keeps actual on target change
// - Watch one enable; clear resets status bit 8
// - Watch one compares above or below setpoint
// - Watch two enable; clear resets status bit 9
// - Watch two compares above or below setpoint
// - Stop ramps over decel time or instantly
// - Coast command or disable always coasts
// - Find-home plus start begins homing sequence
// - Redefine bit forces position to zero
// - Home direction bit reverses home speed sign
// - Return-home drives position back to zero
// - Switch homing seeks switch change; not with marker
// - Marker homing finds marker, returns to it
// - Homing bits inert from revision 3.001 on
package pcw_pkg;

  // --------------------------------------------------------------
  // Register map (byte addresses)
  // --------------------------------------------------------------
  localparam logic [7:0] PCW_ADDR_CTRL = 8'h00;
  localparam logic [7:0] PCW_ADDR_STATUS = 8'h04;
  localparam logic [7:0] PCW_ADDR_W1_SP = 8'h08;
  localparam logic [7:0] PCW_ADDR_W2_SP = 8'h0C;
  localparam logic [7:0] PCW_ADDR_TARGET = 8'h10;
  localparam logic [7:0] PCW_ADDR_DECEL = 8'h14;
  localparam logic [7:0] PCW_ADDR_OFFSET = 8'h18;
  localparam logic [7:0] PCW_ADDR_HOME_SPD = 8'h1C;
  localparam logic [7:0] PCW_ADDR_ACTUAL = 8'h20;

  localparam logic [31:0] PCW_CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] PCW_ZERO = 32'h0000_0000;

  // --------------------------------------------------------------
  // Control word bit positions
  // --------------------------------------------------------------
  localparam int PCW_B_SPD_OUT_EN = 1;
  localparam int PCW_B_INTEG_EN = 2;
  localparam int PCW_B_INTEG_HOLD = 3;
  localparam int PCW_B_OFF_POL = 4;
  localparam int PCW_B_OFF_REREF = 5;
  localparam int PCW_B_ABS_MODE = 6;
  localparam int PCW_B_ZERO_ACC = 9;
  localparam int PCW_B_P2P_REREF = 10;
  localparam int PCW_B_W1_EN = 16;
  localparam int PCW_B_W1_DIR = 17;
  localparam int PCW_B_W2_EN = 18;
  localparam int PCW_B_W2_DIR = 19;
  localparam int PCW_B_RAMP_HALT = 20;
  localparam int PCW_B_FIND_HOME = 24;
  localparam int PCW_B_REDEFINE = 25;
  localparam int PCW_B_HOME_DIR = 26;
  localparam int PCW_B_RETURN_HOME = 27;
  localparam int PCW_B_HOME_SW = 28;
  localparam int PCW_B_HOME_MARK = 29;

  // --------------------------------------------------------------
  // Status word bit positions
  // --------------------------------------------------------------
  localparam int PCW_S_W1 = 8;
  localparam int PCW_S_W2 = 9;
  localparam int PCW_S_HOME_LO = 12;
  localparam int PCW_S_HOMED = 16;
  localparam int PCW_S_RAMPING = 17;
  localparam int PCW_S_HALTED = 18;
  localparam int PCW_S_COAST = 19;

  // --------------------------------------------------------------
  // Regulator gains as right shifts, revision gate
  // --------------------------------------------------------------
  localparam int PCW_KP_SHIFT = 2;
  localparam int PCW_KI_SHIFT = 6;
  localparam int PCW_HOME_RETIRED_REV = 3001;
  localparam int PCW_FW_REV_DEFAULT = 3000;

  typedef enum logic [2:0] {
    PCW_HOME_IDLE = 3'b000,
    PCW_HOME_SEEK = 3'b001,
    PCW_HOME_BACK = 3'b010,
    PCW_HOME_DONE = 3'b011
  } pcw_home_t;

  typedef enum logic [1:0] {
    PCW_HALT_NONE = 2'b00,
    PCW_HALT_RAMP = 2'b01,
    PCW_HALT_ZERO = 2'b10
  } pcw_halt_t;

endpackage

// ---- include/pcw_watch_if.sv ----
// Purpose: Carries one position watch between the core and a comparator
// Assumes: Same clock on both sides
// Notes: The flag is registered inside the comparator
`timescale 1ns/1ps
interface pcw_watch_if;
  logic signed [31:0] actual;
  logic signed [31:0] setpoint;
  logic enable;
  logic direction;
  logic flag;
  modport cmp (input actual, input setpoint, input enable, input direction, output flag);
  modport ctl (output actual, output setpoint, output enable, output direction, input flag);
endinterface

// ---- verilog/pcw_watch.sv ----
// Purpose: One position watch comparator with a registered flag
// Assumes: Evaluated on every control update clock
// Notes: Equality sets neither direction
`timescale 1ns/1ps
module pcw_watch
  import pcw_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Watch signals
  pcw_watch_if.cmp w
);

  typedef struct packed {
    logic flag;
  } pcw_watch_st_t;

  pcw_watch_st_t s_r;
  pcw_watch_st_t s_nxt;

  always_comb begin
    s_nxt = s_r;
    if (!w.enable) begin
      s_nxt.flag = 1'b0;
    end else if (w.direction) begin
      s_nxt.flag = (w.actual > w.setpoint);
    end else begin
      s_nxt.flag = (w.actual < w.setpoint);
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign w.flag = s_r.flag;

endmodule

// ---- verilog/pcw_top.sv ----
// Purpose: Position loop control word, watches, stop handling and homing
// Assumes: Feedback and commands come from logic on this clock; switch and
//          marker are pins and are synchronised here
// Notes: Reset is drive disable; all state returns to constants
//
// Decided for this implementation: the register offsets and strobed register access.
`timescale 1ns/1ps
module pcw_top
  import pcw_pkg::*;
#(
  parameter int FW_REV_MILLI = PCW_FW_REV_DEFAULT
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Register port
  input wire logic [7:0] addr,
  input wire logic [31:0] wr_data,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [31:0] rd_data,
  // Drive commands
  input wire logic drive_enable,
  input wire logic drive_running,
  input wire logic start_cmd,
  input wire logic stop_cmd,
  input wire logic coast_cmd,
  // Feedback and pins
  input wire logic signed [31:0] pos_fbk,
  input wire logic home_switch,
  input wire logic marker_pulse,
  // Speed regulator side
  output logic signed [31:0] pos_spd_out,
  output logic pos_spd_valid,
  output logic coast_out,
  output logic signed [31:0] pos_actual,
  output logic watch_one_flag,
  output logic watch_two_flag,
  output logic home_busy
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [31:0] ctrl;
    logic signed [31:0] sp1;
    logic signed [31:0] sp2;
    logic signed [31:0] target;
    logic [31:0] decel;
    logic signed [31:0] offset;
    logic signed [31:0] home_spd;
    logic signed [31:0] base;
    logic signed [31:0] off_latch;
    logic signed [31:0] integ;
    logic signed [31:0] actual;
    logic signed [31:0] spd;
    logic signed [31:0] ramp_spd;
    logic signed [31:0] ramp_step;
    logic [31:0] ramp_cnt;
    logic signed [31:0] mark_pos;
    logic [31:0] rdata;
    pcw_home_t home;
    pcw_halt_t halt;
    logic valid;
    logic coast;
    logic homed;
    logic sw_start;
    logic en_d;
    logic sw_s1;
    logic sw_s2;
    logic mk_s1;
    logic mk_s2;
    logic mk_d;
  } pcw_st_t;

  pcw_st_t s_r;
  pcw_st_t s_nxt;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic signed [31:0] neg_if(input logic signed [31:0] v, input logic c);
    neg_if = c ? -v : v;
  endfunction

  function automatic logic signed [31:0] mag(input logic signed [31:0] v);
    mag = (v < 0) ? -v : v;
  endfunction

  // Homing bits are inert from the retired revision onward
  localparam logic HOME_LIVE = (FW_REV_MILLI < PCW_HOME_RETIRED_REV);

  // ----------------------------------------------------------------
  // Watches
  // ----------------------------------------------------------------
  pcw_watch_if w1 ();
  pcw_watch_if w2 ();

  assign w1.actual = s_r.actual;
  assign w1.setpoint = s_r.sp1;
  assign w1.enable = s_r.ctrl[PCW_B_W1_EN];
  assign w1.direction = s_r.ctrl[PCW_B_W1_DIR];
  assign w2.actual = s_r.actual;
  assign w2.setpoint = s_r.sp2;
  assign w2.enable = s_r.ctrl[PCW_B_W2_EN];
  assign w2.direction = s_r.ctrl[PCW_B_W2_DIR];

  pcw_watch u_watch_one (
    .clock(clock),
    .rst(rst),
    .w(w1.cmp)
  );

  pcw_watch u_watch_two (
    .clock(clock),
    .rst(rst),
    .w(w2.cmp)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  logic [31:0] c;
  logic home_find;
  logic home_redef;
  logic home_rev;
  logic home_ret;
  logic home_sw;
  logic home_mk;
  logic signed [31:0] off_eff;
  logic signed [31:0] err;
  logic signed [31:0] reg_out;
  logic signed [31:0] home_cmd;
  logic signed [31:0] tgt_eff;
  logic mk_rise;

  always_comb begin
    s_nxt = s_r;
    c = s_r.ctrl;
    home_find = HOME_LIVE && c[PCW_B_FIND_HOME];
    home_redef = HOME_LIVE && c[PCW_B_REDEFINE];
    home_rev = HOME_LIVE && c[PCW_B_HOME_DIR];
    home_ret = HOME_LIVE && c[PCW_B_RETURN_HOME];
    home_sw = HOME_LIVE && c[PCW_B_HOME_SW];
    home_mk = HOME_LIVE && c[PCW_B_HOME_MARK] && !c[PCW_B_HOME_SW];
    mk_rise = s_r.mk_s2 && !s_r.mk_d;
    home_cmd = neg_if(s_r.home_spd, home_rev);

    // Pin synchronisers
    s_nxt.sw_s1 = home_switch;
    s_nxt.sw_s2 = s_r.sw_s1;
    s_nxt.mk_s1 = marker_pulse;
    s_nxt.mk_s2 = s_r.mk_s1;
    s_nxt.mk_d = s_r.mk_s2;
    s_nxt.en_d = drive_enable;

    // Offset with polarity; latched at enable so a later change is relative
    off_eff = neg_if(s_r.offset, c[PCW_B_OFF_POL]);
    if (drive_enable && !s_r.en_d) begin
      s_nxt.off_latch = off_eff;
    end

    // Register writes
    if (wr_stb) begin
      case (addr)
        PCW_ADDR_CTRL: s_nxt.ctrl = wr_data;
        PCW_ADDR_W1_SP: s_nxt.sp1 = wr_data;
        PCW_ADDR_W2_SP: s_nxt.sp2 = wr_data;
        PCW_ADDR_TARGET: begin
          s_nxt.target = wr_data;
          // Without re-reference a new target re-bases actual to zero
          if (!c[PCW_B_P2P_REREF]) begin
            s_nxt.base = pos_fbk;
          end
        end
        PCW_ADDR_DECEL: s_nxt.decel = wr_data;
        PCW_ADDR_OFFSET: begin
          s_nxt.offset = wr_data;
          // Re-reference absorbs the offset step so actual does not jump
          if (c[PCW_B_OFF_REREF]) begin
            s_nxt.off_latch = s_r.off_latch - off_eff
                              + neg_if($signed(wr_data), c[PCW_B_OFF_POL]);
          end
        end
        PCW_ADDR_HOME_SPD: s_nxt.home_spd = wr_data;
        default: begin
        end
      endcase
    end

    // Accumulator zeroing and redefine
    if (c[PCW_B_ZERO_ACC] && c[PCW_B_ABS_MODE] && !drive_running) begin
      s_nxt.base = pos_fbk;
      s_nxt.off_latch = off_eff;
      s_nxt.integ = PCW_ZERO;
    end
    if (home_redef) begin
      s_nxt.base = pos_fbk;
      s_nxt.off_latch = off_eff;
    end

    // Actual position relative to base and offset reference
    s_nxt.actual = pos_fbk - s_r.base - (off_eff - s_r.off_latch);

    // Regulator
    tgt_eff = home_ret ? PCW_ZERO : s_r.target;
    err = tgt_eff - s_r.actual;
    if (!c[PCW_B_INTEG_EN]) begin
      s_nxt.integ = PCW_ZERO;
    end else if (!c[PCW_B_INTEG_HOLD]) begin
      s_nxt.integ = s_r.integ + (err >>> PCW_KI_SHIFT);
    end
    reg_out = (err >>> PCW_KP_SHIFT) + s_r.integ;

    // Homing sequence
    case (s_r.home)
      PCW_HOME_IDLE: begin
        if (home_find && start_cmd) begin
          s_nxt.home = PCW_HOME_SEEK;
          s_nxt.sw_start = s_r.sw_s2;
          s_nxt.homed = 1'b0;
        end
      end
      PCW_HOME_SEEK: begin
        if (home_sw && (s_r.sw_s2 != s_r.sw_start)) begin
          s_nxt.home = PCW_HOME_DONE;
          s_nxt.base = pos_fbk;
        end else if (home_mk && mk_rise) begin
          s_nxt.mark_pos = pos_fbk;
          s_nxt.home = PCW_HOME_BACK;
        end else if (!home_sw && !home_mk) begin
          s_nxt.home = PCW_HOME_DONE;
        end
      end
      PCW_HOME_BACK: begin
        // Travelled past the marker; done once feedback crosses back to it
        if ((home_cmd >= 0) ? (pos_fbk <= s_r.mark_pos) : (pos_fbk >= s_r.mark_pos)) begin
          s_nxt.home = PCW_HOME_DONE;
          s_nxt.base = s_r.mark_pos;
        end
      end
      PCW_HOME_DONE: begin
        s_nxt.homed = 1'b1;
        s_nxt.home = PCW_HOME_IDLE;
      end
      default: s_nxt.home = PCW_HOME_IDLE;
    endcase

    // Stop handling
    case (s_r.halt)
      PCW_HALT_NONE: begin
        if (stop_cmd) begin
          if (c[PCW_B_RAMP_HALT] && (s_r.decel != PCW_ZERO)) begin
            s_nxt.halt = PCW_HALT_RAMP;
            s_nxt.ramp_spd = s_r.spd;
            s_nxt.ramp_step = mag(s_r.spd) / $signed({1'b0, s_r.decel[30:0]});
            s_nxt.ramp_cnt = s_r.decel;
          end else begin
            s_nxt.halt = PCW_HALT_ZERO;
          end
          s_nxt.home = PCW_HOME_IDLE;
        end
      end
      PCW_HALT_RAMP: begin
        if (s_r.ramp_cnt <= 32'h0000_0001) begin
          s_nxt.halt = PCW_HALT_ZERO;
          s_nxt.ramp_spd = PCW_ZERO;
        end else begin
          s_nxt.ramp_cnt = s_r.ramp_cnt - 32'h0000_0001;
          s_nxt.ramp_spd = (s_r.ramp_spd >= 0) ? s_r.ramp_spd - s_r.ramp_step
                                               : s_r.ramp_spd + s_r.ramp_step;
        end
        if (start_cmd) begin
          s_nxt.halt = PCW_HALT_NONE;
        end
      end
      PCW_HALT_ZERO: begin
        if (start_cmd) begin
          s_nxt.halt = PCW_HALT_NONE;
        end
      end
      default: s_nxt.halt = PCW_HALT_NONE;
    endcase

    // Coast overrides every stop mode
    s_nxt.coast = coast_cmd || !drive_enable;
    if (s_nxt.coast) begin
      s_nxt.halt = PCW_HALT_NONE;
      s_nxt.home = PCW_HOME_IDLE;
    end

    // Speed output selection
    if (s_nxt.coast) begin
      s_nxt.spd = PCW_ZERO;
      s_nxt.valid = 1'b0;
    end else if (s_r.halt == PCW_HALT_RAMP) begin
      s_nxt.spd = s_r.ramp_spd;
      s_nxt.valid = 1'b1;
    end else if (s_r.halt == PCW_HALT_ZERO) begin
      s_nxt.spd = PCW_ZERO;
      s_nxt.valid = 1'b1;
    end else if (s_r.home == PCW_HOME_SEEK) begin
      s_nxt.spd = home_cmd;
      s_nxt.valid = 1'b1;
    end else if (s_r.home == PCW_HOME_BACK) begin
      s_nxt.spd = -home_cmd;
      s_nxt.valid = 1'b1;
    end else if (c[PCW_B_SPD_OUT_EN]) begin
      s_nxt.spd = reg_out;
      s_nxt.valid = 1'b1;
    end else begin
      s_nxt.spd = PCW_ZERO;
      s_nxt.valid = 1'b0;
    end

    // Read data, valid in the cycle after the strobe
    s_nxt.rdata = PCW_ZERO;
    if (rd_stb) begin
      case (addr)
        PCW_ADDR_CTRL: s_nxt.rdata = s_r.ctrl;
        PCW_ADDR_STATUS: begin
          s_nxt.rdata[PCW_S_W1] = w1.flag;
          s_nxt.rdata[PCW_S_W2] = w2.flag;
          s_nxt.rdata[PCW_S_HOME_LO +: 3] = s_r.home;
          s_nxt.rdata[PCW_S_HOMED] = s_r.homed;
          s_nxt.rdata[PCW_S_RAMPING] = (s_r.halt == PCW_HALT_RAMP);
          s_nxt.rdata[PCW_S_HALTED] = (s_r.halt == PCW_HALT_ZERO);
          s_nxt.rdata[PCW_S_COAST] = s_r.coast;
        end
        PCW_ADDR_W1_SP: s_nxt.rdata = s_r.sp1;
        PCW_ADDR_W2_SP: s_nxt.rdata = s_r.sp2;
        PCW_ADDR_TARGET: s_nxt.rdata = s_r.target;
        PCW_ADDR_DECEL: s_nxt.rdata = s_r.decel;
        PCW_ADDR_OFFSET: s_nxt.rdata = s_r.offset;
        PCW_ADDR_HOME_SPD: s_nxt.rdata = s_r.home_spd;
        PCW_ADDR_ACTUAL: s_nxt.rdata = s_r.actual;
        default: s_nxt.rdata = PCW_ZERO;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s_r <= '0;
      s_r.ctrl <= PCW_CTRL_RESET;
      s_r.coast <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign rd_data = s_r.rdata;
  assign pos_spd_out = s_r.spd;
  assign pos_spd_valid = s_r.valid;
  assign coast_out = s_r.coast;
  assign pos_actual = s_r.actual;
  assign watch_one_flag = w1.flag;
  assign watch_two_flag = w2.flag;
  assign home_busy = (s_r.home == PCW_HOME_SEEK) || (s_r.home == PCW_HOME_BACK);

endmodule

// ---- tb/pcw_chk.sv ----
// Purpose: Port assertions for the position control block
// Assumes: Control word and setpoints are mirrored here from register writes
// Notes: Watch checks need two cycles of a condition so compare latency is covered
`timescale 1ns/1ps
module pcw_chk
  import pcw_pkg::*;
#(
  parameter int FW_REV_MILLI = PCW_FW_REV_DEFAULT
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Register port
  input wire logic [7:0] addr,
  input wire logic [31:0] wr_data,
  input wire logic wr_stb,
  input wire logic rd_stb,
  input wire logic [31:0] rd_data,
  // Drive commands and feedback
  input wire logic drive_enable,
  input wire logic drive_running,
  input wire logic start_cmd,
  input wire logic stop_cmd,
  input wire logic coast_cmd,
  input wire logic signed [31:0] pos_fbk,
  // Block outputs
  input wire logic signed [31:0] pos_spd_out,
  input wire logic pos_spd_valid,
  input wire logic coast_out,
  input wire logic signed [31:0] pos_actual,
  input wire logic watch_one_flag,
  input wire logic watch_two_flag,
  input wire logic home_busy
);
  logic [31:0] ctrl_r;
  logic signed [31:0] sp1_r;
  logic signed [31:0] sp2_r;
  logic w1_on;
  logic w2_on;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ctrl_r <= PCW_CTRL_RESET;
      sp1_r <= PCW_ZERO;
      sp2_r <= PCW_ZERO;
    end else if (wr_stb) begin
      if (addr == PCW_ADDR_CTRL) ctrl_r <= wr_data;
      if (addr == PCW_ADDR_W1_SP) sp1_r <= wr_data;
      if (addr == PCW_ADDR_W2_SP) sp2_r <= wr_data;
    end
  end

  assign w1_on = ctrl_r[PCW_B_W1_EN] &&
    (ctrl_r[PCW_B_W1_DIR] ? pos_actual > sp1_r : pos_actual < sp1_r);
  assign w2_on = ctrl_r[PCW_B_W2_EN] &&
    (ctrl_r[PCW_B_W2_DIR] ? pos_actual > sp2_r : pos_actual < sp2_r);

  default clocking @(posedge clock); endclocking
  default disable iff (rst);

  rd_idle_a: assert property (!rd_stb |=> rd_data == PCW_ZERO)
    else $error("read data not zero outside read cycle");
  ctrl_readback_a: assert property (rd_stb && addr == PCW_ADDR_CTRL |=> rd_data == ctrl_r)
    else $error("control word read back wrong");
  unmapped_read_a: assert property (rd_stb && addr > PCW_ADDR_ACTUAL |=> rd_data == PCW_ZERO)
    else $error("unmapped read not zero");
  watch_one_set_a: assert property (w1_on [*2] |-> watch_one_flag)
    else $error("watch one flag missing");
  watch_one_clr_a: assert property ((!w1_on) [*2] |-> !watch_one_flag)
    else $error("watch one flag set wrongly");
  watch_two_set_a: assert property (w2_on [*2] |-> watch_two_flag)
    else $error("watch two flag missing");
  watch_two_clr_a: assert property ((!w2_on) [*2] |-> !watch_two_flag)
    else $error("watch two flag set wrongly");
  coast_stop_a: assert property (coast_cmd || !drive_enable |=>
    coast_out && !pos_spd_valid && pos_spd_out == 32'sh0)
    else $error("coast did not stop output");
  out_gate_a: assert property ((!ctrl_r[PCW_B_SPD_OUT_EN] && !home_busy) [*2]
    |-> !pos_spd_valid)
    else $error("speed output driven while disabled");
  halt_zero_a: assert property (stop_cmd && !ctrl_r[PCW_B_RAMP_HALT] && !home_busy
    ##1 !start_cmd |=> pos_spd_out == 32'sh0)
    else $error("instant stop left speed");
  set_zero_a: assert property ((ctrl_r[PCW_B_ABS_MODE] && ctrl_r[PCW_B_ZERO_ACC]
    && !drive_running && $stable(pos_fbk)) [*3] |-> pos_actual == PCW_ZERO)
    else $error("set zero did not clear position");
  redefine_a: assert property ((FW_REV_MILLI < PCW_HOME_RETIRED_REV
    && ctrl_r[PCW_B_REDEFINE] && $stable(pos_fbk)) [*3] |-> pos_actual == PCW_ZERO)
    else $error("redefine did not zero position");
endmodule

bind pcw_top pcw_chk #(.FW_REV_MILLI(FW_REV_MILLI)) chk_u (
  .clock(clock), .rst(rst), .addr(addr), .wr_data(wr_data), .wr_stb(wr_stb),
  .rd_stb(rd_stb), .rd_data(rd_data), .drive_enable(drive_enable),
  .drive_running(drive_running), .start_cmd(start_cmd), .stop_cmd(stop_cmd),
  .coast_cmd(coast_cmd), .pos_fbk(pos_fbk), .pos_spd_out(pos_spd_out),
  .pos_spd_valid(pos_spd_valid), .coast_out(coast_out), .pos_actual(pos_actual),
  .watch_one_flag(watch_one_flag), .watch_two_flag(watch_two_flag),
  .home_busy(home_busy)
);

// ---- tb/pcw_plant_model.sv ----
// Purpose: Motor and feedback stand-in driven by the block's speed output
// Assumes: Speed integrates into position at one sixteenth per update
// Notes: Switch and marker sit at fixed positions along the travel
`timescale 1ns/1ps
module pcw_plant_model
  import pcw_pkg::*;
#(
  parameter int SW_POS = 300,
  parameter int MARK_POS = 320
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Bench nudge and speed command
  input wire logic signed [31:0] nudge,
  input wire logic signed [31:0] spd,
  input wire logic spd_valid,
  // Feedback and pins
  output logic signed [31:0] pos_fbk,
  output logic home_switch,
  output logic marker_pulse
);
  // Speed counts only while the block claims the output
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pos_fbk <= 32'sh0;
    end else begin
      pos_fbk <= pos_fbk + nudge + (spd_valid ? (spd >>> 4) : 32'sh0);
    end
  end
  assign home_switch = pos_fbk >= SW_POS;
  assign marker_pulse = (pos_fbk >= MARK_POS) && (pos_fbk < MARK_POS + 8);
endmodule

// ---- tb/tb_top.sv ----
// Purpose: Register level tests of control word, watches, stops and homing
// Assumes: One 10 MHz clock; reads sampled mid-cycle after the strobe
// Notes: Positions are steered by the plant nudge, and by the speed output once it is enabled or homing runs
`timescale 1ns/1ps
module tb_top;
  import pcw_pkg::*;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [31:0] wr_data = 32'h0;
  logic wr_stb = 1'b0;
  logic rd_stb = 1'b0;
  logic drive_enable = 1'b1;
  logic drive_running = 1'b0;
  logic start_cmd = 1'b0;
  logic stop_cmd = 1'b0;
  logic coast_cmd = 1'b0;
  logic signed [31:0] nudge = 32'sh0;
  logic [31:0] rd_data;
  logic signed [31:0] pos_fbk;
  logic signed [31:0] pos_spd_out;
  logic signed [31:0] pos_actual;
  logic home_switch, marker_pulse, pos_spd_valid, coast_out;
  logic watch_one_flag, watch_two_flag, home_busy;
  logic [31:0] d;
  int miscompares = 0;
  int total_checks = 0;
  int cycles = 0;
  logic [31:0] wctl [3] = '{32'h0007_0000, 32'h000D_0000, 32'h0006_0000};
  logic [1:0] wexp [3] = '{2'b11, 2'b00, 2'b10};

  always #50 clock = ~clock;

  pcw_top dut_u (.clock(clock), .rst(rst), .addr(addr), .wr_data(wr_data),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data(rd_data), .drive_enable(drive_enable),
    .drive_running(drive_running), .start_cmd(start_cmd), .stop_cmd(stop_cmd),
    .coast_cmd(coast_cmd), .pos_fbk(pos_fbk), .home_switch(home_switch),
    .marker_pulse(marker_pulse), .pos_spd_out(pos_spd_out), .pos_spd_valid(pos_spd_valid),
    .coast_out(coast_out), .pos_actual(pos_actual), .watch_one_flag(watch_one_flag),
    .watch_two_flag(watch_two_flag), .home_busy(home_busy));

  pcw_plant_model #(.SW_POS(1000)) plant_u (.clock(clock), .rst(rst), .nudge(nudge),
    .spd(pos_spd_out),
    .spd_valid(pos_spd_valid), .pos_fbk(pos_fbk), .home_switch(home_switch),
    .marker_pulse(marker_pulse));

  // ----------------------------------------------------------------
  // Bus and check tasks
  // ----------------------------------------------------------------
  task automatic wt(input int n);
    repeat (n) @(posedge clock);
    @(negedge clock);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clock);
    addr <= a;
    wr_data <= v;
    wr_stb <= 1'b1;
    @(posedge clock);
    wr_stb <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge clock);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge clock);
    rd_stb <= 1'b0;
    @(negedge clock);
    d = rd_data;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_nz(input string what, input logic [31:0] got);
    total_checks++;
    if (got === 32'h0 || $isunknown(got)) begin
      miscompares++;
      $display("[FAIL] %s expected nonzero seen %h", what, got);
    end
  endtask

  task automatic pulse_stop();
    @(posedge clock);
    stop_cmd <= 1'b1;
    @(posedge clock);
    stop_cmd <= 1'b0;
  endtask

  task automatic pulse_start();
    @(posedge clock);
    start_cmd <= 1'b1;
    @(posedge clock);
    start_cmd <= 1'b0;
  endtask

  task automatic summarize();
    if (miscompares == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Hang guard, well beyond the longest homing walk
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      summarize();
    end
  end

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    rd(PCW_ADDR_CTRL);
    chk("ctrl reset", PCW_CTRL_RESET, d);
    rd(8'h24);
    chk("unmapped read", 32'h0, d);
    wr(PCW_ADDR_W1_SP, 32'h0000_0014);
    rd(PCW_ADDR_W1_SP);
    chk("w1 setpoint", 32'h0000_0014, d);
    wr(PCW_ADDR_W2_SP, 32'h0000_0050);
    wr(PCW_ADDR_CTRL, 32'h0000_0240);
    wt(4);
    chk("set zero", 32'h0, pos_actual);
    @(posedge clock);
    drive_running <= 1'b1;
    nudge <= 32'sh5;
    repeat (10) @(posedge clock);
    nudge <= 32'sh0;
    wt(4);
    chk("set zero while running", 32'h0000_0032, pos_actual);
    for (int i = 0; i < 3; i++) begin
      wr(PCW_ADDR_CTRL, wctl[i]);
      wt(3);
      chk("watch one", {31'h0, wexp[i][0]}, {31'h0, watch_one_flag});
      chk("watch two", {31'h0, wexp[i][1]}, {31'h0, watch_two_flag});
      rd(PCW_ADDR_STATUS);
      chk("status watches", {30'h0, wexp[i]}, {30'h0, d[9:8]});
    end
    @(posedge clock);
    coast_cmd <= 1'b1;
    wt(2);
    chk("coast out", 32'h1, {31'h0, coast_out});
    chk("coast valid", 32'h0, {31'h0, pos_spd_valid});
    @(posedge clock);
    coast_cmd <= 1'b0;
    wr(PCW_ADDR_CTRL, 32'h0000_0400);
    wr(PCW_ADDR_TARGET, 32'h0000_0190);
    wt(2);
    chk("target keeps actual", 32'h0000_0032, pos_actual);
    wr(PCW_ADDR_CTRL, 32'h0000_0406);
    wt(3);
    chk("output enabled", 32'h1, {31'h0, pos_spd_valid});
    pulse_stop();
    wt(1);
    chk("instant stop", 32'h0, pos_spd_out);
    pulse_start();
    wr(PCW_ADDR_DECEL, 32'h0000_0004);
    wr(PCW_ADDR_CTRL, 32'h0010_0406);
    wt(5);
    pulse_stop();
    wt(1);
    chk_nz("ramp start", pos_spd_out);
    wt(8);
    chk("ramp end", 32'h0, pos_spd_out);
    pulse_start();
    // Switch homing only; marker bit stays clear alongside it
    wr(PCW_ADDR_HOME_SPD, 32'h0000_0320);
    wr(PCW_ADDR_CTRL, 32'h1100_0002);
    pulse_start();
    wt(3);
    chk("homing started", 32'h1, {31'h0, home_busy});
    for (int n = 0; n < 3000 && home_busy; n++) wt(0);
    rd(PCW_ADDR_STATUS);
    chk("homed", 32'h1, {31'h0, d[PCW_S_HOMED]});
    wr(PCW_ADDR_CTRL, 32'h0200_0000);
    wt(4);
    chk("redefine", 32'h0, pos_actual);
    wr(PCW_ADDR_CTRL, 32'h0000_0010);
    wr(PCW_ADDR_OFFSET, 32'h0000_0005);
    wt(2);
    chk("offset sign", 32'h5, pos_actual);
    wr(PCW_ADDR_CTRL, 32'h0000_0030);
    wr(PCW_ADDR_OFFSET, 32'h0000_0009);
    wt(2);
    chk("offset reref", 32'h5, pos_actual);
    wr(PCW_ADDR_HOME_SPD, 32'h0000_0040);
    wr(PCW_ADDR_CTRL, 32'h2500_0000);
    pulse_start();
    wt(3);
    chk("marker seek", 32'h1, {31'h0, home_busy});
    for (int n = 0; n < 3000 && home_busy; n++) wt(0);
    rd(PCW_ADDR_STATUS);
    chk("marker homed", 32'h1, {31'h0, d[PCW_S_HOMED]});
    summarize();
  end
endmodule
